// *** dv/mm_master_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module mm_master_model (
	input  wire logic                   sys_clk_i,
	input  wire mm_burst_pkg::bus_rsp_t bus_rsp_i,
	output mm_burst_pkg::bus_req_t      bus_req_o
);
	import mm_burst_pkg::*;
	initial bus_req_o = '0;
	// Aligned word addresses, length 1..15, marker only on a burst's first beat
	task automatic beat(input bus_req_t r);
		@(negedge sys_clk_i);
		bus_req_o <= r;
		// Held whole until an edge sees stall low
		do @(posedge sys_clk_i); while (bus_rsp_i.stall !== 1'b0);
	endtask
	// Address and write data flip so stale values are never mistaken for held ones
	task automatic idle();
		@(negedge sys_clk_i);
		bus_req_o.read <= 1'b0;
		bus_req_o.write <= 1'b0;
		bus_req_o.burst_first <= 1'b0;
		bus_req_o.addr <= ~bus_req_o.addr;
		bus_req_o.wdata <= ~bus_req_o.wdata;
	endtask
endmodule
`default_nettype wire

// *** dv/test_mm_burst_slave.sv ***
`timescale 1ns/100ps
`default_nettype none
module test_mm_burst_slave;
	import mm_burst_pkg::*;
	typedef struct packed {
		logic [9:0]  addr;
		logic [3:0]  be;
		logic [31:0] wdata;
		logic [3:0]  rbe;
		logic [31:0] exp;
	} row_t;
	logic        sys_clk_i     = 1'b0;
	logic        rst_i         = 1'b1;
	logic        return_hold_i = 1'b0;
	logic        ce_i          = 1'b1;
	bus_req_t    bus_req;
	bus_rsp_t    bus_rsp;
	logic [31:0] got [$];
	int          got_t [$];
	int          takes [$];
	int          cyc        = 0;
	int          errors     = 0;
	int          n_compared = 0;
	row_t        rows [4]   = '{
		'{10'h001, 4'hf, 32'h11223344, 4'hf, 32'h11223344},
		'{10'h002, 4'h5, 32'haabbccdd, 4'hf, 32'h00bb00dd},
		'{10'h03f, 4'ha, 32'h55667788, 4'h3, 32'h00007700},
		'{10'h001, 4'h8, 32'h99000000, 4'hc, 32'h99220000}};

	always #2.5 sys_clk_i = ~sys_clk_i;

	mm_burst_slave mm_burst_slave_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(ce_i), .bus_req_i(bus_req),
		.return_hold_i(return_hold_i), .bus_rsp_o(bus_rsp));
	mm_master_model mm_master_model_i (.sys_clk_i(sys_clk_i), .bus_rsp_i(bus_rsp), .bus_req_o(bus_req));

	always @(posedge sys_clk_i)
	begin
		cyc <= cyc + 1;
		if (!rst_i && bus_rsp.rvalid === 1'b1)
		begin
			got.push_back(bus_rsp.rdata);
			got_t.push_back(cyc);
		end
		// Whole run needs well under a thousand cycles
		if (cyc == 20000)
		begin
			errors++;
			print_verdict();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			errors++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic go(input logic [9:0] a, input logic [3:0] l, b, input logic [31:0] d, input logic rd, wr, f, w);
		mm_master_model_i.beat('{a, l, b, d, rd, wr, f, w});
		if (rd)
			takes.push_back(cyc);
	endtask

	task automatic word(input logic [31:0] e, input bit s);
		int k;
		mm_master_model_i.idle();
		for (k = 0; k < 300 && got.size() == 0; k++)
			@(negedge sys_clk_i);
		if (got.size() == 0)
			check('x, e);
		else
		begin
			if (s)
				check(got_t[0] - takes.pop_front(), READ_DELAY);
			check(got.pop_front(), e);
			got_t.delete(0);
		end
	endtask

	task automatic print_verdict();
		$display("Compared %0d, mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial
	begin
		repeat (8) @(negedge sys_clk_i);
		rst_i = 1'b0;
		@(negedge sys_clk_i);
		check(bus_rsp.rdata, '0);
		check({bus_rsp.stall, bus_rsp.rvalid}, '0);
		foreach (rows[i])
		begin
			go(rows[i].addr, 1, rows[i].be, rows[i].wdata, 0, 1, 1, 0);
			go(rows[i].addr, 1, rows[i].rbe, '0, 1, 0, 1, 0);
			word(rows[i].exp, 1);
		end
		// Reads accepted while earlier ones are still owed
		for (int i = 0; i < 3; i++)
			go(10'(i + 1), 1, 4'hf, '0, 1, 0, 1, 0);
		check(takes[2] - takes[0], 2);
		takes.delete();
		word(32'h99223344, 0);
		word(32'h00bb00dd, 0);
		word(32'h00000000, 0);
		// Later beats carry a junk address: slave must count internally
		go(10'h008, 4, 4'hf, 32'ha0a0a0a0, 0, 1, 1, 0);
		go(10'h3ff, 4, 4'h3, 32'hb1b1b1b1, 0, 1, 0, 0);
		mm_master_model_i.idle();
		go(10'h3ff, 4, 4'hc, 32'hc2c2c2c2, 0, 1, 0, 0);
		go(10'h3ff, 4, 4'hf, 32'hd3d3d3d3, 0, 1, 0, 0);
		go(10'h008, 4, 4'hf, '0, 1, 0, 1, 0);
		go(10'h008, 2, 4'h6, '0, 1, 0, 1, 0);
		check(takes[1] - takes[0], 4);
		takes.delete();
		word(32'ha0a0a0a0, 0);
		word(32'h0000b1b1, 0);
		word(32'hc2c20000, 0);
		word(32'hd3d3d3d3, 0);
		word(32'h00a0a000, 0);
		word(32'h0000b100, 0);
		for (int k = 0; k < 8; k++)
			go(k == 0 ? 10'h010 : 10'h3ff, 8, 4'hf, 32'h100 + k, 0, 1, k == 0, 0);
		go(10'h015, 8, 4'hf, '0, 1, 0, 1, 1);
		go(10'h008, 2, 4'hf, '0, 1, 0, 1, 0);
		for (int k = 0; k < 8; k++)
			word(32'h100 + (k + 5) % 8, 0);
		word(32'ha0a0a0a0, 0);
		word(32'h0000b1b1, 0);
		// Held return path: FIFO fills, the second burst is taken but waits for credit, the third is held off
		return_hold_i = 1'b1;
		fork
			for (int j = 0; j < 3; j++)
				go(10'h010, 8, 4'hf, '0, 1, 0, 1, 0);
			begin
				repeat (40) @(negedge sys_clk_i);
				check(got.size(), 0);
				return_hold_i = 1'b0;
			end
		join
		for (int k = 0; k < 24; k++)
			word(32'h100 + k % 8, 0);
		repeat (20) @(negedge sys_clk_i);
		check(got.size(), 0);
		// Frozen clock enable: a taken read must not return until it is raised again
		go(10'h001, 1, 4'hf, '0, 1, 0, 1, 0);
		mm_master_model_i.idle();
		ce_i = 1'b0;
		repeat (10) @(negedge sys_clk_i);
		check(got.size(), 0);
		ce_i = 1'b1;
		word(32'h99223344, 0);
		// Reset in mid-run clears the store and the response
		mm_master_model_i.idle();
		rst_i = 1'b1;
		repeat (2) @(negedge sys_clk_i);
		rst_i = 1'b0;
		@(negedge sys_clk_i);
		check({bus_rsp.stall, bus_rsp.rvalid}, '0);
		go(10'h001, 1, 4'hf, '0, 1, 0, 1, 0);
		word(32'h00000000, 0);
		check(got.size(), 0);
		print_verdict();
	end
endmodule
`default_nettype wire

// *** logic/mm_burst_pkg.sv ***
`default_nettype none
package mm_burst_pkg;
	localparam int DATA_W          = 32;
	localparam int BE_W            = DATA_W / 8;
	localparam int ADDR_W          = 10;
	localparam int LEN_W           = 4;
	localparam int MEM_AW          = 6;
	localparam int FIFO_DEPTH      = 8;
	localparam int READ_DELAY      = 3;
	localparam int MIN_READ_DELAY  = 3;
	localparam int LINE_WORDS      = 8;
	localparam int LANE_W          = 8;

	// Request from the fabric, one beat per clock
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [LEN_W-1:0]  len;
		logic [BE_W-1:0]   be;
		logic [DATA_W-1:0] wdata;
		logic              read;
		logic              write;
		logic              burst_first;
		logic              wrap;
	} bus_req_t;

	// Answer to the fabric
	typedef struct packed {
		logic [DATA_W-1:0] rdata;
		logic              rvalid;
		logic              stall;
	} bus_rsp_t;
endpackage
`default_nettype wire

// *** logic/mm_burst_slave.sv ***
`timescale 1ns/100ps
`default_nettype none

module mm_burst_fifo #(
	parameter int W     = 32,
	parameter int DEPTH = 8
) (
	input  wire logic                       sys_clk_i,
	input  wire logic                       rst_i,
	input  wire logic                       ce_i,
	input  wire logic                       in_valid_i,
	output logic                            in_ready_o,
	input  wire logic [W-1:0]               in_data_i,
	output logic                            out_valid_o,
	input  wire logic                       out_ready_i,
	output logic [W-1:0]                    out_data_o,
	output logic [$clog2(DEPTH+1)-1:0]      level_o
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [PW-1:0]           wp;
		logic [PW-1:0]           rp;
		logic [CW-1:0]           cnt;
	} fifo_st_t;

	fifo_st_t s;
	fifo_st_t next_s;
	logic     push;
	logic     pop;

	always_comb
	begin
		next_s = s;
		push = in_valid_i && (s.cnt != CW'(DEPTH));
		pop = out_ready_i && (s.cnt != '0);
		if (push)
		begin
			next_s.mem[s.wp] = in_data_i;
			next_s.wp = (s.wp == PW'(DEPTH - 1)) ? '0 : s.wp + 1'b1;
		end
		if (pop)
			next_s.rp = (s.rp == PW'(DEPTH - 1)) ? '0 : s.rp + 1'b1;
		if (push && !pop)
			next_s.cnt = s.cnt + 1'b1;
		else if (pop && !push)
			next_s.cnt = s.cnt - 1'b1;
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
			s <= '0;
		else if (ce_i)
			s <= next_s;
	end

	assign in_ready_o  = (s.cnt != CW'(DEPTH));
	assign out_valid_o = (s.cnt != '0);
	assign out_data_o  = s.mem[s.rp];
	assign level_o     = s.cnt;
endmodule

module mm_burst_slave #(
	parameter int MEM_WORDS_LOG = mm_burst_pkg::MEM_AW,
	parameter int RD_DELAY      = mm_burst_pkg::READ_DELAY,
	parameter int LINE_LEN      = mm_burst_pkg::LINE_WORDS,
	parameter int RET_DEPTH     = mm_burst_pkg::FIFO_DEPTH,
	parameter bit HOLD_FIELDS   = 1'b0
) (
	input  wire logic                   sys_clk_i,
	input  wire logic                   rst_i,
	input  wire logic                   ce_i,
	input  wire mm_burst_pkg::bus_req_t bus_req_i,
	input  wire logic                   return_hold_i,
	output mm_burst_pkg::bus_rsp_t      bus_rsp_o
);
	import mm_burst_pkg::*;

	// HOLD_FIELDS is informational: burst fields are always taken on the first beat
	localparam int PIPE  = RD_DELAY - 2;
	localparam int LW    = $clog2(LINE_LEN);
	localparam int LVW   = $clog2(RET_DEPTH + 1);
	localparam int IFW   = $clog2(PIPE + 1);
	localparam int CRW   = LVW + IFW + 1;

	typedef struct packed {
		logic [PIPE-1:0]                          pv;
		logic [PIPE-1:0][DATA_W-1:0]              pd;
		logic [(1<<MEM_WORDS_LOG)-1:0][DATA_W-1:0] mem;
		logic [ADDR_W-1:0]                        rd_addr;
		logic [LEN_W-1:0]                         rd_left;
		logic [BE_W-1:0]                          rd_be;
		logic                                     rd_wrap;
		logic [ADDR_W-1:0]                        wr_addr;
		logic [LEN_W-1:0]                         wr_left;
		logic                                     wr_wrap;
		bus_rsp_t                                 rsp;
	} st_t;

	st_t                s;
	st_t                next_s;
	logic               fifo_ready;
	logic               fifo_valid;
	logic [DATA_W-1:0]  fifo_data;
	logic [LVW-1:0]     fifo_level;
	logic               pop;
	logic               rd_take;
	logic               wr_take;
	logic               issue;
	logic               credit;
	logic [IFW-1:0]     inflight;
	logic [ADDR_W-1:0]  issue_addr;
	logic [BE_W-1:0]    issue_be;
	logic [ADDR_W-1:0]  wa;
	logic [DATA_W-1:0]  lane_mask;

	function automatic logic [ADDR_W-1:0] step_addr(input logic [ADDR_W-1:0] a, input logic wrap);
		logic [ADDR_W-1:0] r;
		r = a + 1'b1;
		if (wrap)
			r = {a[ADDR_W-1:LW], LW'(a[LW-1:0] + 1'b1)};
		return r;
	endfunction

	function automatic logic [DATA_W-1:0] expand_be(input logic [BE_W-1:0] be);
		logic [DATA_W-1:0] m;
		m = '0;
		for (int i = 0; i < BE_W; i++)
			m[i*LANE_W +: LANE_W] = {LANE_W{be[i]}};
		return m;
	endfunction

	// Zero-length requests are illegal; treated as one beat
	function automatic logic [LEN_W-1:0] beats_after_first(input logic [LEN_W-1:0] len);
		return (len == '0) ? '0 : len - 1'b1;
	endfunction

	always_comb
	begin
		inflight = '0;
		for (int i = 0; i < PIPE; i++)
			inflight = inflight + IFW'(s.pv[i]);
	end

	// Every issued beat owns a FIFO slot, so the return FIFO never refuses a push
	assign credit = (CRW'(fifo_level) + CRW'(inflight)) < CRW'(RET_DEPTH);

	// Stall is registered, so it cannot form a loop with read or write
	assign rd_take = bus_req_i.read && !s.rsp.stall;
	assign wr_take = bus_req_i.write && !s.rsp.stall;
	assign pop     = fifo_valid && !return_hold_i;

	always_comb
	begin
		next_s = s;
		issue = 1'b0;
		issue_addr = s.rd_addr;
		issue_be = s.rd_be;
		wa = s.wr_addr;
		lane_mask = '0;

		// Read command: capture address, length and lanes once
		if (rd_take)
		begin
			next_s.rd_addr = bus_req_i.addr;
			next_s.rd_be = bus_req_i.be;
			next_s.rd_wrap = bus_req_i.wrap;
			next_s.rd_left = (bus_req_i.len == '0) ? LEN_W'(1) : bus_req_i.len;
			if (credit)
			begin
				issue = 1'b1;
				issue_addr = bus_req_i.addr;
				issue_be = bus_req_i.be;
				next_s.rd_addr = step_addr(bus_req_i.addr, bus_req_i.wrap);
				next_s.rd_left = beats_after_first(bus_req_i.len);
			end
		end
		else if (s.rd_left != '0 && credit)
		begin
			issue = 1'b1;
			next_s.rd_addr = step_addr(s.rd_addr, s.rd_wrap);
			next_s.rd_left = s.rd_left - 1'b1;
		end

		// Return pipeline; memory reads change nothing
		next_s.pv[0] = issue;
		next_s.pd[0] = s.mem[issue_addr[MEM_WORDS_LOG-1:0]] & expand_be(issue_be);
		for (int i = 1; i < PIPE; i++)
		begin
			next_s.pv[i] = s.pv[i-1];
			next_s.pd[i] = s.pd[i-1];
		end

		// Write beats: sampled only while write is high
		if (wr_take)
		begin
			if (s.wr_left == '0)
			begin
				wa = bus_req_i.addr;
				next_s.wr_wrap = bus_req_i.wrap;
				next_s.wr_left = beats_after_first(bus_req_i.len);
				next_s.wr_addr = step_addr(bus_req_i.addr, bus_req_i.wrap);
			end
			else
			begin
				next_s.wr_left = s.wr_left - 1'b1;
				next_s.wr_addr = step_addr(s.wr_addr, s.wr_wrap);
			end
			lane_mask = expand_be(bus_req_i.be);
			next_s.mem[wa[MEM_WORDS_LOG-1:0]] = (s.mem[wa[MEM_WORDS_LOG-1:0]] & ~lane_mask)
				| (bus_req_i.wdata & lane_mask);
		end

		// Return stage: FIFO keeps acceptance order
		next_s.rsp.rvalid = pop;
		if (pop)
			next_s.rsp.rdata = fifo_data;

		// Hold off new commands while a read burst still has beats to issue
		next_s.rsp.stall = (next_s.rd_left != '0);
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
			s <= '0;
		else if (ce_i)
			s <= next_s;
	end

	mm_burst_fifo #(
		.W     (DATA_W),
		.DEPTH (RET_DEPTH)
	) u_ret_fifo (
		.sys_clk_i   (sys_clk_i),
		.rst_i       (rst_i),
		.ce_i        (ce_i),
		.in_valid_i  (s.pv[PIPE-1]),
		.in_ready_o  (fifo_ready),
		.in_data_i   (s.pd[PIPE-1]),
		.out_valid_o (fifo_valid),
		.out_ready_i (pop),
		.out_data_o  (fifo_data),
		.level_o     (fifo_level)
	);

	assign bus_rsp_o = s.rsp;

	// Checks below watch only what this block drives
	a_stall_busy: assert property (@(posedge sys_clk_i) disable iff (rst_i || !ce_i)
		(rd_take && (bus_req_i.len > LEN_W'(1) || !credit)) |=> s.rsp.stall)
		else $error("stall low while read beats remain");

	a_take_stalled: assert property (@(posedge sys_clk_i) disable iff (rst_i || !ce_i)
		(bus_req_i.read && s.rsp.stall) |=> $stable(s.rd_be) && $stable(s.rd_wrap))
		else $error("read command taken during stall");

	a_read_load: assert property (@(posedge sys_clk_i) disable iff (rst_i || !ce_i)
		(rd_take && !credit && bus_req_i.len != '0) |=> (s.rd_left == $past(bus_req_i.len)))
		else $error("read length not captured");

	a_beat_count: assert property (@(posedge sys_clk_i) disable iff (rst_i || !ce_i)
		(!rd_take && s.rd_left != '0 && credit) |=> (s.rd_left == $past(s.rd_left) - 1'b1) && s.pv[0])
		else $error("beat counter did not step on issue");

	a_wrap_line: assert property (@(posedge sys_clk_i) disable iff (rst_i || !ce_i)
		(issue && !rd_take && s.rd_wrap) |=> (s.rd_addr[ADDR_W-1:LW] == $past(s.rd_addr[ADDR_W-1:LW])))
		else $error("wrapped burst left its line");

	a_write_beat: assert property (@(posedge sys_clk_i) disable iff (rst_i || !ce_i)
		(!bus_req_i.write && s.wr_left != '0) |=> $stable(s.wr_left) && $stable(s.wr_addr))
		else $error("write burst advanced without write");

	a_read_lanes: assert property (@(posedge sys_clk_i) disable iff (rst_i || !ce_i)
		issue |=> ((s.pd[0] & ~expand_be($past(issue_be))) == '0))
		else $error("unselected lane carried read data");

	a_credit_room: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		s.pv[PIPE-1] |-> fifo_ready)
		else $error("return beat pushed into full fifo");

	a_return_lat: assert property (@(posedge sys_clk_i) disable iff (rst_i || !ce_i)
		(s.pv[PIPE-1] && fifo_level == '0) |=> fifo_valid ##1 (s.rsp.rvalid || $past(return_hold_i)))
		else $error("return path latency broken");

	a_valid_pulse: assert property (@(posedge sys_clk_i) disable iff (rst_i || !ce_i)
		(fifo_valid && !return_hold_i) |=> s.rsp.rvalid && (s.rsp.rdata == $past(fifo_data)))
		else $error("return word not presented with valid");

	a_stall_clear: assert property (@(posedge sys_clk_i) disable iff (rst_i || !ce_i)
		(s.rsp.stall && s.rd_left == LEN_W'(1) && credit) |=> !s.rsp.stall)
		else $error("stall held after last beat issued");

	a_single_beat: assert property (@(posedge sys_clk_i) disable iff (rst_i || !ce_i)
		(rd_take && credit && bus_req_i.len == LEN_W'(1)) |=> (s.rd_left == '0) && s.pv[0] && !s.rsp.stall)
		else $error("single read issued more than one beat");

	a_write_load: assert property (@(posedge sys_clk_i) disable iff (rst_i || !ce_i)
		(wr_take && s.wr_left == '0 && bus_req_i.len != '0) |=> (s.wr_left == $past(bus_req_i.len) - 1'b1))
		else $error("write burst length not captured");

	a_write_lanes: assert property (@(posedge sys_clk_i) disable iff (rst_i || !ce_i)
		wr_take |=> ((s.mem[$past(wa[MEM_WORDS_LOG-1:0])] & $past(lane_mask))
			== ($past(bus_req_i.wdata) & $past(lane_mask))))
		else $error("selected write lanes not stored");

	a_rdata_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i || !ce_i)
		!pop |=> $stable(s.rsp.rdata))
		else $error("return word changed without valid");

	a_wrap_first: assert property (@(posedge sys_clk_i) disable iff (rst_i || !ce_i)
		(rd_take && credit && bus_req_i.wrap)
			|=> (s.rd_addr[ADDR_W-1:LW] == $past(bus_req_i.addr[ADDR_W-1:LW])))
		else $error("wrapped burst start left its line");
endmodule
`default_nettype wire
